// ---- dv/tb.sv ----
// Self-checking testbench for the error reporting block
`timescale 1ns/1ps
module tb import ter_pkg::*;;
    localparam logic [31:0] B_MALF = 32'h1 << UNC_MALF;
    localparam logic [31:0] B_UR = 32'h1 << UNC_UR;
    localparam logic [31:0] B_PERR = 32'h1 << LST_DET_PERR;
    localparam logic [31:0] SEV0 = 32'(UNC_SEV_RST);
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    ter_event_s ev = '0;
    ter_reg_req_s rq = '0;
    logic req_valid = 1'b0;
    logic mapped = 1'b0;
    logic fwd, iur, irq;
    ter_msg_s msg;
    logic [31:0] rdata, cmd_v, dc_v, sev_v, n_exp;
    logic [31:0] lfsr = 32'h909a;
    logic [127:0] hdr;
    logic [15:0] n_msg;
    logic [3:0] kinds [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    ter_error_report #(.IS_BRIDGE(1'b1)) ter_error_report_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .event_i(ev),
        .req_valid_i(req_valid), .addr_mapped_i(mapped), .fwd_o(fwd),
        .ingress_ur_o(iur), .msg_o(msg), .reg_i(rq), .rdata_o(rdata),
        .irq_o(irq));
    ter_rc_model ter_rc_model_i (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .msg_i(msg), .n_msg_o(n_msg));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Flags are {malformed, unexpected completion, unsupported, posted}
    function automatic logic [2:0] expect_msg(input logic [3:0] f);
        logic fat;
        if (f[3]) begin
            fat = sev_v[UNC_MALF];
            return {dc_v[fat ? DCT_FAT_EN : DCT_NF_EN] | cmd_v[CMD_SERR_EN],
                fat, 1'b1};
        end
        if (f[1]) begin
            fat = sev_v[UNC_UR];
            if (!fat && !f[0])
                return {dc_v[DCT_UR_EN] & dc_v[DCT_COR_EN], 2'h0};
            return {dc_v[DCT_UR_EN] & dc_v[fat ? DCT_FAT_EN : DCT_NF_EN]
                | cmd_v[CMD_SERR_EN], fat, 1'b1};
        end
        return {f[2] & dc_v[DCT_COR_EN], 2'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        rq <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk_i);
        rq.wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        rq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk_i);
        rq.rd <= 1'b0;
        #1 chk(rdata & m, e);
        @(posedge ref_clk_i);
    endtask

    task automatic cfg(input logic [31:0] c, d, s);
        wr(REG_CMD, c);
        wr(REG_DEV_CTRL, d);
        wr(REG_UNC_SEV, s);
        cmd_v = c;
        dc_v = d;
        sev_v = s;
    endtask

    task automatic fire(input logic [3:0] f);
        logic [2:0] e;
        e = expect_msg(f);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            hdr = {hdr[95:0], lfsr};
        end
        ev <= '{f[3], f[2], f[1], f[0], hdr};
        @(posedge ref_clk_i);
        ev <= '0;
        #1 chk(32'(msg.valid), 32'(e[2]));
        if (e[2])
            chk(32'(msg.kind), 32'(e[1:0]));
        n_exp = n_exp + 32'(e[2]);
        @(posedge ref_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        cmd_v = 32'h0;
        dc_v = 32'h0;
        sev_v = SEV0;
        n_exp = 32'h0;
        repeat (4) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        rd(REG_DEV_CAP, 32'h8000, 32'h8000);
        rd(REG_UNC_SEV, '1, SEV0);
        rd(8'hfc, '1, 32'h0);
        fire(4'h8);
        for (int i = 0; i < HDR_WORDS; i++)
            rd(REG_HDR0 + 8'(4 * i), '1, hdr[127 - 32 * i -: 32]);
        rd(REG_UNC_STS, B_MALF, B_MALF);
        rd(REG_LEGACY_STS, B_PERR, B_PERR);
        cfg(32'h0, 32'hf, SEV0);
        fire(4'h8);
        chk(32'(irq), 32'h0);
        wr(REG_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(REG_IRQ_STS, 32'h3);
        chk(32'(irq), 32'h0);
        wr(REG_LEGACY_STS, B_PERR);
        rd(REG_LEGACY_STS, B_PERR, 32'h0);
        rd(REG_UNC_STS, B_MALF, B_MALF);
        fire(4'h8);
        wr(REG_UNC_STS, B_MALF);
        rd(REG_UNC_STS, B_MALF, 32'h0);
        rd(REG_LEGACY_STS, B_PERR, B_PERR);
        cfg(32'h0, 32'hf, 32'h0);
        fire(4'h8);
        cfg(32'h1 << CMD_SERR_EN, 32'h0, SEV0);
        fire(4'h2);
        fire(4'h3);
        rd(REG_UNC_STS, B_UR, B_UR);
        cfg(32'h0, 32'h1, SEV0);
        fire(4'h4);
        rd(REG_COR_STS, 32'h2000, 32'h2000);
        for (int i = 0; i < 2; i++) begin
            req_valid <= 1'b1;
            mapped <= i[0];
            #1 chk(32'({fwd, iur}), i ? 32'h2 : 32'h1);
            @(posedge ref_clk_i);
        end
        req_valid <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            lfsr = nxt(lfsr);
            cfg(32'(lfsr[4]) << CMD_SERR_EN, 32'(lfsr[3:0]),
                32'({lfsr[8], 1'b0, lfsr[7]}) << UNC_MALF);
            fire(kinds[lfsr[6:5]]);
        end
        #1 chk(32'(n_msg), n_exp);
        finish_test();
    end
endmodule // tb

// ---- dv/ter_error_report_properties.sv ----
// Port checks for the error reporting block
`timescale 1ns/1ps
module ter_error_report_checker import ter_pkg::*; #(
    parameter bit ROLE_BASED = 1'b1,
    parameter bit IS_BRIDGE = 1'b0
) (
    // Design inputs
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire ter_event_s event_i,
    input wire logic req_valid_i,
    input wire logic addr_mapped_i,
    input wire ter_reg_req_s reg_i,
    // Design outputs
    input wire logic fwd_o,
    input wire logic ingress_ur_o,
    input wire ter_msg_s msg_o,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_msg_has_cause: assert property (
        msg_o.valid |-> $past(event_i.malformed || event_i.unexp_cpl
        || event_i.unsup_req || (IS_BRIDGE && req_valid_i && !addr_mapped_i)))
        else $error("message without an error");
    a_malf_uncorr: assert property (
        $past(event_i.malformed) && msg_o.valid
        |-> msg_o.kind != TER_MSG_COR) else $error("malformed sent as cor");
    a_cpl_cor: assert property (
        $past(event_i.unexp_cpl && !event_i.malformed && !event_i.unsup_req
        && !(IS_BRIDGE && req_valid_i && !addr_mapped_i))
        && msg_o.valid |-> msg_o.kind == TER_MSG_COR)
        else $error("unexpected completion not cor");
    a_posted_ur_unc: assert property (
        $past(event_i.unsup_req && event_i.posted && !event_i.malformed)
        && msg_o.valid |-> msg_o.kind != TER_MSG_COR)
        else $error("posted unsupported request sent as cor");
    a_cap_role: assert property (
        $past(reg_i.rd) && $past(reg_i.addr) == REG_DEV_CAP
        |-> rdata_o[CAP_ROLE_BASED] == ROLE_BASED)
        else $error("role based capability bit wrong");
    a_unmapped_ur: assert property (
        IS_BRIDGE && req_valid_i && !addr_mapped_i |-> ingress_ur_o && !fwd_o)
        else $error("unmapped request not ended at ingress");
    a_mapped_fwd: assert property (
        IS_BRIDGE && req_valid_i && addr_mapped_i && !event_i.malformed
        |-> fwd_o && !ingress_ur_o)
        else $error("mapped request not forwarded");
    a_bridge_excl: assert property (
        !(fwd_o && ingress_ur_o)) else $error("forward and end together");
    c_fatal: cover property (msg_o.valid && msg_o.kind == TER_MSG_FATAL);
    c_nonfatal: cover property (msg_o.valid && msg_o.kind == TER_MSG_NONFATAL);
    c_cor: cover property (msg_o.valid && msg_o.kind == TER_MSG_COR);
endmodule // ter_error_report_checker

bind ter_error_report ter_error_report_checker #(
    .ROLE_BASED(ROLE_BASED), .IS_BRIDGE(IS_BRIDGE)
) ter_error_report_checker_i (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .event_i(event_i),
    .req_valid_i(req_valid_i), .addr_mapped_i(addr_mapped_i), .reg_i(reg_i),
    .fwd_o(fwd_o), .ingress_ur_o(ingress_ur_o), .msg_o(msg_o),
    .rdata_o(rdata_o), .irq_o(irq_o)
);

// ---- dv/ter_rc_model.sv ----
// Root complex side model that counts received error messages
`timescale 1ns/1ps
module ter_rc_model import ter_pkg::*; (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Message from the block
    input wire ter_msg_s msg_i,
    // Count of messages taken
    output logic [15:0] n_msg_o
);
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            n_msg_o <= 16'h0;
        end else if (msg_i.valid) begin
            n_msg_o <= n_msg_o + 16'h1;
        end
    end
endmodule // ter_rc_model

// ---- hw/ter_error_report.sv ----
// Transaction-layer error detection, logging and message selection
//
// Behaviour
// - Detected errors set their status bits
// - Malformed TLP: ERR_FATAL and log header
// - Unexpected completion: ERR_COR and log header
// - Unsupported requests obey extra enable controls
// - Non-role-based: UR reporting off, no message
// - Role-based with system-error enable may report UR
// - Role-based, enables clear: non-posted UR silent
// - Role-based, enables clear: posted UR nonfatal
// - Capability bit advertises role-based reporting
// - Malformed TLPs, ingress URs and signalled system errors mirrored into legacy status bits
// - Legacy status clear leaves error status
// - Error status clear leaves legacy status
// - Command enables never gate error status
// - Bridge forwards or ends TLP at ingress
// - Unmapped request ends as unsupported request
// - Severity programmable when advanced reporting present
// - Actions follow enables, masks and severities
`timescale 1ns/1ps
module ter_error_report import ter_pkg::*; #(
    parameter bit ROLE_BASED = 1'b1,
    parameter bit ADV_ERR = 1'b1,
    parameter bit IS_BRIDGE = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Error events
    input wire ter_event_s event_i,
    input wire logic req_valid_i,
    input wire logic addr_mapped_i,
    // Bridge routing
    output logic fwd_o,
    output logic ingress_ur_o,
    // Error message to the root complex
    output ter_msg_s msg_o,
    // Register port
    input wire ter_reg_req_s reg_i,
    output logic [31:0] rdata_o,
    // Interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Software-visible registers
    logic [15:0] cmd;
    logic [15:0] legacy_sts;
    logic [3:0] dev_ctrl;
    logic [UNC_W-1:0] unc_sts;
    logic [UNC_W-1:0] unc_mask;
    logic [UNC_W-1:0] unc_sev;
    logic [COR_W-1:0] cor_sts;
    logic [COR_W-1:0] cor_mask;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_mask;
    // Header log and its word view
    logic [127:0] hdr_log;
    logic hdr_valid;
    logic [31:0] hdr_word [HDR_WORDS];
    // Event decode
    logic ur_hit;
    logic any_err;
    logic hdr_take;
    logic malf_fatal;
    logic ur_fatal;
    logic serr_en;
    logic malf_sev_en;
    logic ur_sev_en;
    ter_msg_s next_msg;
    // Set and clear vectors of the sticky registers
    logic [UNC_W-1:0] unc_set;
    logic [COR_W-1:0] cor_set;
    logic [15:0] legacy_set;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0] unc_clr;
    logic [31:0] cor_clr;
    logic [31:0] legacy_clr;
    logic [31:0] irq_clr;
    // Read path
    logic [7:0] hdr_off;
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Register port decode
    function automatic logic wr_to(input ter_reg_req_s r,
        input logic [7:0] a);
        wr_to = r.wr && (r.addr == a);
    endfunction

    // Write-one-to-clear mask, zero when the register is not written
    function automatic logic [31:0] clr_mask(input ter_reg_req_s r,
        input logic [7:0] a);
        if (wr_to(r, a)) begin
            clr_mask = r.wdata;
        end else begin
            clr_mask = '0;
        end
    endfunction

    // Reporting enable of the given severity
    function automatic logic sev_enable(input logic [3:0] ctrl,
        input logic fatal);
        if (fatal) begin
            sev_enable = ctrl[DCT_FAT_EN];
        end else begin
            sev_enable = ctrl[DCT_NF_EN];
        end
    endfunction

    // Message kind of an uncorrectable error
    function automatic ter_msg_e unc_kind(input logic fatal);
        if (fatal) begin
            unc_kind = TER_MSG_FATAL;
        end else begin
            unc_kind = TER_MSG_NONFATAL;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Ingress decision of a bridge: unmapped requests end here as UR
    always_comb begin
        ur_hit = event_i.unsup_req;
        fwd_o = 1'b0;
        ingress_ur_o = 1'b0;
        if (IS_BRIDGE && req_valid_i) begin
            fwd_o = addr_mapped_i && !event_i.malformed;
            ingress_ur_o = !addr_mapped_i;
            ur_hit = event_i.unsup_req || !addr_mapped_i;
        end
    end

    assign any_err = event_i.malformed || event_i.unexp_cpl || ur_hit;

    ////////////////////////////////////////////////////////////////////////
    // Severity of each uncorrectable error; fixed without advanced reporting
    always_comb begin
        if (ADV_ERR) begin
            malf_fatal = unc_sev[UNC_MALF];
            ur_fatal = unc_sev[UNC_UR];
        end else begin
            malf_fatal = UNC_SEV_RST[UNC_MALF];
            ur_fatal = UNC_SEV_RST[UNC_UR];
        end
    end

    assign serr_en = cmd[CMD_SERR_EN];
    assign malf_sev_en = sev_enable(dev_ctrl, malf_fatal);
    assign ur_sev_en = sev_enable(dev_ctrl, ur_fatal);

    ////////////////////////////////////////////////////////////////////////
    // Message choice after masks, severity and enables
    // Priority: malformed, then UR, then unexpected completion
    always_comb begin
        next_msg = '0;
        if (event_i.malformed && !unc_mask[UNC_MALF]) begin
            next_msg.kind = unc_kind(malf_fatal);
            next_msg.valid = malf_sev_en || serr_en;
        end else if (ur_hit && !unc_mask[UNC_UR]) begin
            if (!ROLE_BASED) begin
                // The UR enable alone can silence every UR message
                next_msg.kind = unc_kind(ur_fatal);
                next_msg.valid = dev_ctrl[DCT_UR_EN]
                    && (ur_sev_en || serr_en);
            end else if (event_i.posted || ur_fatal) begin
                // System-error enable reports even with UR off
                next_msg.kind = unc_kind(ur_fatal);
                next_msg.valid = (dev_ctrl[DCT_UR_EN] && ur_sev_en)
                    || serr_en;
            end else begin
                // Non-posted nonfatal UR is advisory: correctable message only
                next_msg.kind = TER_MSG_COR;
                next_msg.valid = dev_ctrl[DCT_UR_EN]
                    && dev_ctrl[DCT_COR_EN]
                    && !cor_mask[COR_ADV_NF];
            end
        end else if (event_i.unexp_cpl && !cor_mask[COR_ADV_NF]) begin
            next_msg.kind = TER_MSG_COR;
            next_msg.valid = dev_ctrl[DCT_COR_EN];
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            msg_o <= '0;
        end else begin
            msg_o <= next_msg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd <= '0;
            dev_ctrl <= '0;
            unc_mask <= '0;
            unc_sev <= UNC_SEV_RST;
            cor_mask <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_to(reg_i, REG_CMD)) begin
                cmd <= reg_i.wdata[15:0];
            end
            if (wr_to(reg_i, REG_DEV_CTRL)) begin
                dev_ctrl <= reg_i.wdata[3:0];
            end
            if (wr_to(reg_i, REG_UNC_MASK)) begin
                unc_mask <= reg_i.wdata[UNC_W-1:0];
            end
            if (ADV_ERR && wr_to(reg_i, REG_UNC_SEV)) begin
                unc_sev <= reg_i.wdata[UNC_W-1:0];
            end
            if (wr_to(reg_i, REG_COR_MASK)) begin
                cor_mask <= reg_i.wdata[COR_W-1:0];
            end
            if (wr_to(reg_i, REG_IRQ_MASK)) begin
                irq_mask <= reg_i.wdata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set vectors: hardware events, never gated by command enables
    always_comb begin
        unc_set = '0;
        unc_set[UNC_MALF] = event_i.malformed;
        unc_set[UNC_UR] = ur_hit;
    end

    always_comb begin
        cor_set = '0;
        cor_set[COR_ADV_NF] = event_i.unexp_cpl
            || (ur_hit && !event_i.posted);
    end

    // Legacy mirror of malformed TLPs, ingress URs and signalled system errors
    always_comb begin
        legacy_set = '0;
        legacy_set[LST_DET_PERR] = event_i.malformed;
        legacy_set[LST_SIG_SERR] = next_msg.valid
            && (next_msg.kind != TER_MSG_COR) && serr_en;
        legacy_set[LST_SIG_TABT] = ingress_ur_o;
    end

    assign hdr_take = any_err && !hdr_valid;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_MSG] = next_msg.valid;
        irq_set[IRQ_HDR] = hdr_take;
    end

    // Each register has its own clear path
    assign unc_clr = clr_mask(reg_i, REG_UNC_STS);
    assign cor_clr = clr_mask(reg_i, REG_COR_STS);
    assign legacy_clr = clr_mask(reg_i, REG_LEGACY_STS);
    assign irq_clr = clr_mask(reg_i, REG_IRQ_STS);

    ////////////////////////////////////////////////////////////////////////
    // Error status: set wins over write-one-to-clear
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unc_sts <= '0;
        end else begin
            unc_sts <= (unc_sts & ~unc_clr[UNC_W-1:0]) | unc_set;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cor_sts <= '0;
        end else begin
            cor_sts <= (cor_sts & ~cor_clr[COR_W-1:0]) | cor_set;
        end
    end

    // Legacy status mirror, cleared only through its own address
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            legacy_sts <= '0;
        end else begin
            legacy_sts <= (legacy_sts & ~legacy_clr[15:0])
                | legacy_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Header log: first logged error holds until its interrupt bit clears
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hdr_log <= '0;
        end else if (hdr_take) begin
            hdr_log <= event_i.header;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hdr_valid <= 1'b0;
        end else if (hdr_take) begin
            hdr_valid <= 1'b1;
        end else if (irq_clr[IRQ_HDR]) begin
            hdr_valid <= 1'b0;
        end
    end

    // Word view of the log, first word holds the top bits
    for (genvar w = 0; w < HDR_WORDS; w++) begin : g_hdr_word
        assign hdr_word[w] = hdr_log[127 - 32 * w -: 32];
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and level output
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_sts <= '0;
        end else begin
            irq_sts <= (irq_sts & ~irq_clr[IRQ_W-1:0]) | irq_set;
        end
    end

    assign irq_o = |(irq_sts & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Read decode; header words sit at consecutive word offsets
    assign hdr_off = reg_i.addr - REG_HDR0;

    always_comb begin
        next_rdata = '0;
        if (reg_i.rd) begin
            case (reg_i.addr)
                REG_CMD: begin
                    next_rdata = 32'(cmd);
                end
                REG_LEGACY_STS: begin
                    next_rdata = 32'(legacy_sts);
                end
                REG_DEV_CTRL: begin
                    next_rdata = 32'(dev_ctrl);
                end
                REG_DEV_CAP: begin
                    next_rdata[CAP_ROLE_BASED] = ROLE_BASED;
                end
                REG_UNC_STS: begin
                    next_rdata = 32'(unc_sts);
                end
                REG_UNC_MASK: begin
                    next_rdata = 32'(unc_mask);
                end
                REG_UNC_SEV: begin
                    next_rdata = 32'(unc_sev);
                end
                REG_COR_STS: begin
                    next_rdata = 32'(cor_sts);
                end
                REG_COR_MASK: begin
                    next_rdata = 32'(cor_mask);
                end
                REG_IRQ_STS: begin
                    next_rdata = 32'(irq_sts);
                end
                REG_IRQ_MASK: begin
                    next_rdata = 32'(irq_mask);
                end
                default: begin
                    if ((reg_i.addr >= REG_HDR0)
                        && (reg_i.addr < REG_IRQ_STS)
                        && (reg_i.addr[1:0] == 2'h0)) begin
                        next_rdata = hdr_word[hdr_off[3:2]];
                    end
                end
            endcase
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule // ter_error_report

// ---- hw/ter_pkg.sv ----
// Package for the transaction-layer error reporting block
package ter_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_LEGACY_STS = 8'h04;
    localparam logic [7:0] REG_DEV_CTRL = 8'h08;
    localparam logic [7:0] REG_DEV_CAP = 8'h0c;
    localparam logic [7:0] REG_UNC_STS = 8'h10;
    localparam logic [7:0] REG_UNC_MASK = 8'h14;
    localparam logic [7:0] REG_UNC_SEV = 8'h18;
    localparam logic [7:0] REG_COR_STS = 8'h1c;
    localparam logic [7:0] REG_COR_MASK = 8'h20;
    localparam logic [7:0] REG_HDR0 = 8'h24;
    localparam logic [7:0] REG_IRQ_STS = 8'h34;
    localparam logic [7:0] REG_IRQ_MASK = 8'h38;
    localparam int HDR_WORDS = 4;

    // Command register fields
    localparam int CMD_PERR_EN = 6;
    localparam int CMD_SERR_EN = 8;
    // Legacy status fields
    localparam int LST_SIG_SERR = 14;
    localparam int LST_DET_PERR = 15;
    localparam int LST_SIG_TABT = 11;
    // Device control fields
    localparam int DCT_COR_EN = 0;
    localparam int DCT_NF_EN = 1;
    localparam int DCT_FAT_EN = 2;
    localparam int DCT_UR_EN = 3;
    // Device capability field
    localparam int CAP_ROLE_BASED = 15;
    // Uncorrectable error fields
    localparam int UNC_MALF = 18;
    localparam int UNC_UR = 20;
    localparam int UNC_W = 21;
    localparam logic [UNC_W-1:0] UNC_SEV_RST = 21'h040000;
    // Correctable error fields
    localparam int COR_ADV_NF = 13;
    localparam int COR_W = 14;
    // Interrupt status fields
    localparam int IRQ_MSG = 0;
    localparam int IRQ_HDR = 1;
    localparam int IRQ_W = 2;

    typedef enum logic [1:0] {
        TER_MSG_COR = 2'h0,
        TER_MSG_NONFATAL = 2'h1,
        TER_MSG_FATAL = 2'h3
    } ter_msg_e;

    // Error events from the transaction-layer receive path
    typedef struct packed {
        logic malformed;
        logic unexp_cpl;
        logic unsup_req;
        logic posted;
        logic [127:0] header;
    } ter_event_s;

    typedef struct packed {
        logic valid;
        ter_msg_e kind;
    } ter_msg_s;

    // Register port
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ter_reg_req_s;

endpackage
